/* File: src/mii_port_pkg.sv */
package mii_port_pkg;

  // System clock
  localparam int MCLK_PERIOD_NS = 10;

  // Management clock timing
  localparam int MGMT_PERIOD_NS = 400;
  localparam int MGMT_HALF_NS = MGMT_PERIOD_NS / 2;
  localparam int MGMT_HALF_CYC_RAW = MGMT_HALF_NS / MCLK_PERIOD_NS;
  localparam int MGMT_HALF_CYC = (MGMT_HALF_CYC_RAW < 1) ? 1 : MGMT_HALF_CYC_RAW;
  localparam int DIV_W = 8;
  localparam logic [DIV_W-1:0] MGMT_HALF_DEF = DIV_W'(MGMT_HALF_CYC);
  localparam logic [DIV_W-1:0] DIV_ZERO = 8'h00;
  localparam logic [DIV_W-1:0] DIV_ONE = 8'h01;

  // Link widths
  localparam int NIB_W = 4;
  localparam int PHY_ADDR_W = 5;
  localparam int REG_ADDR_W = 5;
  localparam int MGMT_DATA_W = 16;

  // Management frame layout, bit 0 is first on the wire
  localparam int PREAMBLE_BITS = 32;
  localparam int CODE_W = 2;
  localparam int TA_FIRST = PREAMBLE_BITS + 2 * CODE_W + PHY_ADDR_W + REG_ADDR_W;
  localparam int DATA_FIRST = TA_FIRST + CODE_W;
  localparam int FRAME_BITS = DATA_FIRST + MGMT_DATA_W;
  localparam int BIT_W = 6;
  localparam logic [BIT_W-1:0] BIT_LAST = BIT_W'(FRAME_BITS - 1);
  localparam logic [BIT_W-1:0] BIT_ZERO = 6'h00;
  localparam logic [BIT_W-1:0] BIT_ONE = 6'h01;
  localparam logic [PREAMBLE_BITS-1:0] PREAMBLE = 32'hffff_ffff;
  localparam logic [CODE_W-1:0] START_CODE = 2'h1;
  localparam logic [CODE_W-1:0] OP_READ = 2'h2;
  localparam logic [CODE_W-1:0] OP_WRITE = 2'h1;
  localparam logic [CODE_W-1:0] TA_WRITE = 2'h2;

  // Transmit buffer
  localparam int TX_FIFO_DEPTH = 16;

  typedef struct packed {
    logic last;
    logic [NIB_W-1:0] nibble;
  } tx_beat_s;

  typedef struct packed {
    logic err;
    logic [NIB_W-1:0] nibble;
  } rx_beat_s;

  typedef struct packed {
    logic rd;
    logic [PHY_ADDR_W-1:0] phy_addr;
    logic [REG_ADDR_W-1:0] reg_addr;
    logic [MGMT_DATA_W-1:0] wdata;
  } mgmt_cmd_s;

  typedef enum logic {TX_IDLE, TX_SEND} tx_state_e;
  typedef enum logic {MG_IDLE, MG_RUN} mg_state_e;

endpackage

/* File: src/pin_sync.sv */
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta_q;

  if (W < 1) begin : g_chk
    $error("pin_sync width must be at least one");
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= '0;
      o_q <= '0;
    end else begin
      meta_q <= i_d;
      o_q <= meta_q;
    end
  end
endmodule
`default_nettype wire

/* File: src/stream_fifo.sv */
`timescale 1ns/10ps
`default_nettype none
module stream_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_valid,
  input wire logic [W-1:0] i_data,
  output logic o_ready,
  output logic o_valid,
  output logic [W-1:0] o_data,
  input wire logic i_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wr_q, wr_d, rd_q, rd_d;
  logic push, pop, full, empty;

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("stream_fifo depth must be a power of two, at least two");
  end

  assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  assign empty = (wr_q == rd_q);
  assign o_ready = !full;
  assign o_valid = !empty;
  assign o_data = mem[rd_q[AW-1:0]];
  assign push = i_valid && !full;
  assign pop = i_ready && !empty;

  always_comb begin
    wr_d = push ? wr_q + (AW+1)'(1) : wr_q;
    rd_d = pop ? rd_q + (AW+1)'(1) : rd_q;
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
  end

  // Storage has no reset; only pointers gate it
  always_ff @(posedge i_mclk) begin
    if (push) begin
      mem[wr_q[AW-1:0]] <= i_data;
    end
  end
endmodule
`default_nettype wire

/* File: src/mii_phy_port.sv */
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - Carrier input synchronised before use
// - Receive nibble used only with valid
// - Receive error honoured only while valid
// - Transmit outputs launched on clock rise
// - Receive inputs captured on clock rise
// - Management clock from programmable divider
// - Management clock period 400 ns default
// - Management frame fields in fixed order
// - Release data line only for read turnaround and data
// - Change after rise, sample on rise
// - Transmit error output held low
// - Transmit nibble valid only with enable
// - Full duplex collision blocks new frames
module mii_phy_port #(
  parameter int TX_FIFO_DEPTH = mii_port_pkg::TX_FIFO_DEPTH
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_full_duplex,
  input wire logic [mii_port_pkg::DIV_W-1:0] i_mgmt_clock_divider,
  input wire logic i_phy_tx_clock,
  input wire logic i_phy_rx_clock,
  input wire logic [mii_port_pkg::NIB_W-1:0] i_rx_nibble_in,
  input wire logic i_rx_valid_in,
  input wire logic i_rx_error_in,
  input wire logic i_carrier_sense_in,
  input wire logic i_collision_in,
  output logic [mii_port_pkg::NIB_W-1:0] o_tx_nibble_out,
  output logic o_tx_enable_out,
  output logic o_tx_error_out,
  output logic o_mgmt_clock_out,
  input wire logic i_mdio_in,
  output logic o_mdio_out,
  output logic o_mdio_oe,
  input wire logic i_tx_valid,
  input wire mii_port_pkg::tx_beat_s i_tx_beat,
  output logic o_tx_ready,
  output logic o_tx_underrun,
  output logic o_rx_valid,
  output mii_port_pkg::rx_beat_s o_rx_beat,
  output logic o_rx_end,
  output logic o_carrier,
  output logic o_collision,
  input wire logic i_mgmt_valid,
  input wire mii_port_pkg::mgmt_cmd_s i_mgmt_cmd,
  output logic o_mgmt_ready,
  output logic o_mgmt_done,
  output logic [mii_port_pkg::MGMT_DATA_W-1:0] o_mgmt_rdata
);
  localparam int SYNC_W = 7 + mii_port_pkg::NIB_W;

  if (TX_FIFO_DEPTH < 2) begin : g_chk
    $error("mii_phy_port transmit buffer depth must be at least two");
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and clock edge detection
  logic [SYNC_W-1:0] pins_raw, pins_s;
  logic txc_s, rxc_s, dv_s, er_s, crs_s, col_s, mdi_s;
  logic [mii_port_pkg::NIB_W-1:0] rxd_s;
  logic txc_prev_q, txc_prev_d, rxc_prev_q, rxc_prev_d;
  logic tx_rise, rx_rise;

  assign pins_raw = {i_phy_tx_clock, i_phy_rx_clock, i_rx_nibble_in, i_rx_valid_in,
                     i_rx_error_in, i_carrier_sense_in, i_collision_in, i_mdio_in};

  pin_sync #(.W(SYNC_W)) u_sync (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_d(pins_raw),
    .o_q(pins_s)
  );

  assign {txc_s, rxc_s, rxd_s, dv_s, er_s, crs_s, col_s, mdi_s} = pins_s;
  assign o_carrier = crs_s;
  assign o_collision = col_s;
  assign o_tx_error_out = 1'b0;

  always_comb begin
    txc_prev_d = txc_s;
    rxc_prev_d = rxc_s;
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      txc_prev_q <= 1'b0;
      rxc_prev_q <= 1'b0;
    end else begin
      txc_prev_q <= txc_prev_d;
      rxc_prev_q <= rxc_prev_d;
    end
  end

  assign tx_rise = txc_s && !txc_prev_q;
  assign rx_rise = rxc_s && !rxc_prev_q;

  ////////////////////////////////////////////////////////////////////////
  // Transmit buffer and nibble engine
  logic f_valid, f_pop, can_start;
  mii_port_pkg::tx_beat_s f_beat;
  mii_port_pkg::tx_state_e tx_state_q, tx_state_d;
  logic tx_en_q, tx_en_d, underrun_q, underrun_d;
  logic [mii_port_pkg::NIB_W-1:0] tx_nib_q, tx_nib_d;

  stream_fifo #(.W($bits(mii_port_pkg::tx_beat_s)), .DEPTH(TX_FIFO_DEPTH)) u_txf (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_valid(i_tx_valid),
    .i_data(i_tx_beat),
    .o_ready(o_tx_ready),
    .o_valid(f_valid),
    .o_data(f_beat),
    .i_ready(f_pop)
  );

  always_comb begin
    tx_state_d = tx_state_q;
    tx_en_d = tx_en_q;
    tx_nib_d = tx_nib_q;
    underrun_d = 1'b0;
    f_pop = 1'b0;
    // Collision blocks start in full duplex
    can_start = i_full_duplex ? !col_s : !crs_s;
    // Launch only on transmit clock rise
    if (tx_rise) begin
      case (tx_state_q)
        mii_port_pkg::TX_IDLE: begin
          tx_en_d = 1'b0;
          tx_nib_d = '0;
          if (!tx_en_q && can_start && f_valid) begin
            f_pop = 1'b1;
            tx_en_d = 1'b1;
            tx_nib_d = f_beat.nibble;
            if (!f_beat.last) begin
              tx_state_d = mii_port_pkg::TX_SEND;
            end
          end
        end
        mii_port_pkg::TX_SEND: begin
          // Frame in progress finishes regardless of collision
          if (f_valid) begin
            f_pop = 1'b1;
            tx_nib_d = f_beat.nibble;
            if (f_beat.last) begin
              tx_state_d = mii_port_pkg::TX_IDLE;
            end
          end else begin
            tx_en_d = 1'b0;
            tx_nib_d = '0;
            underrun_d = 1'b1;
            tx_state_d = mii_port_pkg::TX_IDLE;
          end
        end
        default: begin
          tx_state_d = mii_port_pkg::TX_IDLE;
          tx_en_d = 1'b0;
          tx_nib_d = '0;
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_state_q <= mii_port_pkg::TX_IDLE;
      tx_en_q <= 1'b0;
      tx_nib_q <= '0;
      underrun_q <= 1'b0;
    end else begin
      tx_state_q <= tx_state_d;
      tx_en_q <= tx_en_d;
      tx_nib_q <= tx_nib_d;
      underrun_q <= underrun_d;
    end
  end

  assign o_tx_enable_out = tx_en_q;
  assign o_tx_nibble_out = tx_nib_q;
  assign o_tx_underrun = underrun_q;

  ////////////////////////////////////////////////////////////////////////
  // Receive capture
  logic rx_valid_q, rx_valid_d, rx_end_q, rx_end_d, in_frame_q, in_frame_d;
  mii_port_pkg::rx_beat_s rx_beat_q, rx_beat_d;

  always_comb begin
    rx_valid_d = 1'b0;
    rx_end_d = 1'b0;
    rx_beat_d = rx_beat_q;
    in_frame_d = in_frame_q;
    if (rx_rise) begin
      // Nibble and error gated by valid
      if (dv_s) begin
        rx_valid_d = 1'b1;
        rx_beat_d.nibble = rxd_s;
        rx_beat_d.err = er_s;
        in_frame_d = 1'b1;
      end else if (in_frame_q) begin
        rx_end_d = 1'b1;
        in_frame_d = 1'b0;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_valid_q <= 1'b0;
      rx_end_q <= 1'b0;
      rx_beat_q <= '0;
      in_frame_q <= 1'b0;
    end else begin
      rx_valid_q <= rx_valid_d;
      rx_end_q <= rx_end_d;
      rx_beat_q <= rx_beat_d;
      in_frame_q <= in_frame_d;
    end
  end

  assign o_rx_valid = rx_valid_q;
  assign o_rx_beat = rx_beat_q;
  assign o_rx_end = rx_end_q;

  ////////////////////////////////////////////////////////////////////////
  // Management frame master
  mii_port_pkg::mg_state_e mg_state_q, mg_state_d;
  logic [mii_port_pkg::FRAME_BITS-1:0] frame_q, frame_d;
  logic [mii_port_pkg::BIT_W-1:0] bit_q, bit_d;
  logic [mii_port_pkg::DIV_W-1:0] cnt_q, cnt_d, half_q, half_d, half_sel;
  logic mdc_q, mdc_d, rd_q, rd_d, last_q, last_d, oe_q, oe_d, done_q, done_d;
  logic [mii_port_pkg::MGMT_DATA_W-1:0] shift_q, shift_d;

  always_comb begin
    mg_state_d = mg_state_q;
    frame_d = frame_q;
    bit_d = bit_q;
    cnt_d = cnt_q;
    half_d = half_q;
    mdc_d = mdc_q;
    rd_d = rd_q;
    last_d = last_q;
    oe_d = oe_q;
    done_d = 1'b0;
    shift_d = shift_q;
    // Divider input, zero selects 400 ns
    half_sel = (i_mgmt_clock_divider == mii_port_pkg::DIV_ZERO) ?
               mii_port_pkg::MGMT_HALF_DEF : i_mgmt_clock_divider;
    case (mg_state_q)
      mii_port_pkg::MG_IDLE: begin
        if (i_mgmt_valid) begin
          mg_state_d = mii_port_pkg::MG_RUN;
          rd_d = i_mgmt_cmd.rd;
          half_d = half_sel;
          cnt_d = half_sel - mii_port_pkg::DIV_ONE;
          mdc_d = 1'b0;
          bit_d = mii_port_pkg::BIT_ZERO;
          last_d = 1'b0;
          oe_d = 1'b1;
          frame_d = {mii_port_pkg::PREAMBLE, mii_port_pkg::START_CODE,
                     i_mgmt_cmd.rd ? mii_port_pkg::OP_READ : mii_port_pkg::OP_WRITE,
                     i_mgmt_cmd.phy_addr, i_mgmt_cmd.reg_addr,
                     mii_port_pkg::TA_WRITE, i_mgmt_cmd.wdata};
        end
      end
      mii_port_pkg::MG_RUN: begin
        if (cnt_q != mii_port_pkg::DIV_ZERO) begin
          cnt_d = cnt_q - mii_port_pkg::DIV_ONE;
        end else begin
          cnt_d = half_q - mii_port_pkg::DIV_ONE;
          mdc_d = !mdc_q;
          if (!mdc_q) begin
            // Sample at rise, then shift next bit
            if (rd_q && bit_q >= mii_port_pkg::DATA_FIRST) begin
              shift_d = {shift_q[mii_port_pkg::MGMT_DATA_W-2:0], mdi_s};
            end
            if (bit_q == mii_port_pkg::BIT_LAST) begin
              last_d = 1'b1;
            end else begin
              bit_d = bit_q + mii_port_pkg::BIT_ONE;
              frame_d = {frame_q[mii_port_pkg::FRAME_BITS-2:0], 1'b0};
              // Release for read turnaround and data
              oe_d = !(rd_q && bit_q >= mii_port_pkg::TA_FIRST - 1);
            end
          end else if (last_q) begin
            mg_state_d = mii_port_pkg::MG_IDLE;
            oe_d = 1'b0;
            done_d = 1'b1;
          end
        end
      end
      default: begin
        mg_state_d = mii_port_pkg::MG_IDLE;
        mdc_d = 1'b0;
        oe_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mg_state_q <= mii_port_pkg::MG_IDLE;
      frame_q <= '0;
      bit_q <= '0;
      cnt_q <= '0;
      half_q <= mii_port_pkg::MGMT_HALF_DEF;
      mdc_q <= 1'b0;
      rd_q <= 1'b0;
      last_q <= 1'b0;
      oe_q <= 1'b0;
      done_q <= 1'b0;
      shift_q <= '0;
    end else begin
      mg_state_q <= mg_state_d;
      frame_q <= frame_d;
      bit_q <= bit_d;
      cnt_q <= cnt_d;
      half_q <= half_d;
      mdc_q <= mdc_d;
      rd_q <= rd_d;
      last_q <= last_d;
      oe_q <= oe_d;
      done_q <= done_d;
      shift_q <= shift_d;
    end
  end

  assign o_mgmt_clock_out = mdc_q;
  assign o_mdio_out = frame_q[mii_port_pkg::FRAME_BITS-1];
  assign o_mdio_oe = oe_q;
  assign o_mgmt_done = done_q;
  assign o_mgmt_rdata = shift_q;
  assign o_mgmt_ready = (mg_state_q == mii_port_pkg::MG_IDLE);

  ////////////////////////////////////////////////////////////////////////
  // Checks
  logic [8:0] run_cnt_q;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      run_cnt_q <= 9'h001;
    end else if (mdc_d != mdc_q) begin
      run_cnt_q <= 9'h001;
    end else if (run_cnt_q != 9'h1ff) begin
      run_cnt_q <= run_cnt_q + 9'h001;
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  property p_tx_err_low;
    o_tx_error_out == 1'b0;
  endproperty
  a_tx_err_low: assert property (p_tx_err_low) else $error("tx error output not low");

  property p_tx_launch;
    ($changed(o_tx_enable_out) || $changed(o_tx_nibble_out)) |-> $past(tx_rise);
  endproperty
  a_tx_launch: assert property (p_tx_launch) else $error("tx output moved off clock rise");

  property p_tx_idle_nib;
    !o_tx_enable_out |-> o_tx_nibble_out == '0;
  endproperty
  a_tx_idle_nib: assert property (p_tx_idle_nib) else $error("tx nibble set without enable");

  property p_tx_col_block;
    $rose(o_tx_enable_out) |-> !$past(i_full_duplex && col_s);
  endproperty
  a_tx_col_block: assert property (p_tx_col_block) else $error("frame started in collision");

  property p_rx_capture;
    o_rx_valid |-> $past(rx_rise) && $past(dv_s) && o_rx_beat.nibble == $past(rxd_s);
  endproperty
  a_rx_capture: assert property (p_rx_capture) else $error("rx beat not from valid rise");

  property p_rx_err;
    o_rx_valid |-> o_rx_beat.err == $past(er_s && dv_s);
  endproperty
  a_rx_err: assert property (p_rx_err) else $error("rx error flag mismatch");

  property p_mdc_high;
    $fell(o_mgmt_clock_out) |-> $past(run_cnt_q) == {1'b0, half_q};
  endproperty
  a_mdc_high: assert property (p_mdc_high) else $error("mgmt clock high phase wrong");

  property p_read_release;
    (mg_state_q == mii_port_pkg::MG_RUN && rd_q && bit_q >= mii_port_pkg::DATA_FIRST)
      |-> !o_mdio_oe;
  endproperty
  a_read_release: assert property (p_read_release) else $error("line driven in read data");

  property p_write_drive;
    (mg_state_q == mii_port_pkg::MG_RUN && !rd_q) |-> o_mdio_oe;
  endproperty
  a_write_drive: assert property (p_write_drive) else $error("line released in write");

  property p_mdo_after_rise;
    ($changed(o_mdio_out) && $past(mg_state_q) == mii_port_pkg::MG_RUN) |-> $rose(o_mgmt_clock_out);
  endproperty
  a_mdo_after_rise: assert property (p_mdo_after_rise) else $error("mgmt data moved off rise");

  property p_frame_start;
    (i_mgmt_valid && o_mgmt_ready) |=> o_mdio_out && o_mdio_oe && !o_mgmt_clock_out;
  endproperty
  a_frame_start: assert property (p_frame_start) else $error("frame not opened by preamble");

  c_tx_frame: cover property ($fell(o_tx_enable_out) && !o_tx_underrun);
  c_rx_error: cover property (o_rx_valid && o_rx_beat.err);
  c_mgmt_read: cover property (o_mgmt_done && $past(rd_q));
  c_mgmt_write: cover property (o_mgmt_done && !$past(rd_q));
endmodule
`default_nettype wire

/* File: sim/phy_model.sv */
`timescale 1ns/10ps
`default_nettype none
module phy_model (
  input wire logic i_half,
  input wire logic i_busy,
  input wire logic i_col,
  input wire logic [3:0] i_tx_nibble,
  input wire logic i_tx_enable,
  input wire logic i_mdc,
  input wire logic i_mdio,
  output logic o_tx_clk,
  output logic o_rx_clk,
  output logic [3:0] o_rx_nibble,
  output logic o_rx_valid,
  output logic o_rx_error,
  output logic o_carrier,
  output logic o_collision,
  output logic o_mdio_out,
  output logic o_mdio_oe
);
  logic [3:0] txq[$];
  logic [63:0] frame = '0;
  logic [15:0] regs[32];
  logic [15:0] rdata = '0;
  logic rd = 1'b0;
  int bitn = 0;
  realtime mdc_rise = 0;
  realtime mdc_per = 0;

  initial begin
    o_tx_clk = 1'b0;
    o_rx_clk = 1'b0;
    o_rx_nibble = 4'h0;
    o_rx_valid = 1'b0;
    o_rx_error = 1'b0;
    o_mdio_out = 1'b0;
    o_mdio_oe = 1'b0;
    for (int i = 0; i < 32; i++) begin
      regs[i] = 16'h1000 + 16'(i);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Free-running clocks
  always #20 o_tx_clk = ~o_tx_clk;
  always #20 o_rx_clk = ~o_rx_clk;

  assign o_carrier = i_half & (i_busy | i_tx_enable | o_rx_valid);
  assign o_collision = i_col;

  always @(posedge o_tx_clk) begin
    if (i_tx_enable === 1'b1) txq.push_back(i_tx_nibble);
  end

  task automatic rx_cycle(input logic [5:0] row);
    @(negedge o_rx_clk);
    {o_rx_valid, o_rx_error, o_rx_nibble} = row;
    @(posedge o_rx_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Frame decode
  always @(posedge i_mdc) begin
    mdc_per = $realtime - mdc_rise;
    mdc_rise = $realtime;
    frame = {frame[62:0], i_mdio};
    if (bitn < 34 && frame[33:0] == 34'h3_ffff_fffd) bitn = 34;
    else bitn = bitn + 1;
    if (bitn == 36) rd = (frame[1:0] == 2'h2);
    if (bitn == 46) rdata = regs[frame[4:0]];
    if (rd && bitn >= 47 && bitn < 64) begin
      o_mdio_oe <= #2 1'b1;
      o_mdio_out <= #2 (bitn == 47) ? 1'b0 : rdata[63 - bitn];
    end
    if (bitn == 64) begin
      if (!rd) regs[frame[22:18]] = frame[15:0];
      bitn = 0;
    end
  end

  // Release after last data bit
  always @(negedge i_mdc) begin
    if (bitn == 0) o_mdio_oe <= 1'b0;
  end
endmodule
`default_nettype wire

/* File: sim/mii_phy_port_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module mii_phy_port_tb;
  localparam logic [5:0] ROWS [6] = '{6'h25, 6'h3a, 6'h2f, 6'h13, 6'h20, 6'h09};
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic fdx = 1'b0;
  logic busy = 1'b0;
  logic col = 1'b0;
  logic tx_valid = 1'b0;
  logic mgmt_valid = 1'b0;
  logic [7:0] div = 8'h04;
  mii_port_pkg::tx_beat_s tx_beat = '0;
  mii_port_pkg::mgmt_cmd_s mgmt_cmd = '0;
  mii_port_pkg::rx_beat_s rx_beat;
  logic [3:0] tx_nib, prx_nib;
  logic [15:0] rdata;
  logic tx_en, tx_err, mdc, mdio_out, mdio_oe, mdio_line, tx_ready, tx_underrun;
  logic rx_valid, rx_end, carrier, collision, mgmt_ready, mgmt_done;
  logic ptx_clk, prx_clk, prx_dv, prx_er, pcrs, pcol, phy_out, phy_oe;
  logic [4:0] rxq[$];
  logic [4:0] expq[$];
  int failures = 0;
  int checked = 0;
  int underruns = 0;
  int rx_ends = 0;
  int bad = 0;
  int n;

  always #5 mclk = ~mclk;
  // Pull-up when nobody drives
  assign mdio_line = mdio_oe ? mdio_out : (phy_oe ? phy_out : 1'b1);
  logic mdio_dly;
  // Phy sees the level from before the clock edge
  assign #1 mdio_dly = mdio_line;

  mii_phy_port #(.TX_FIFO_DEPTH(16)) dut (
    .i_mclk(mclk), .i_rst_n(rst_n), .i_full_duplex(fdx), .i_mgmt_clock_divider(div),
    .i_phy_tx_clock(ptx_clk), .i_phy_rx_clock(prx_clk), .i_rx_nibble_in(prx_nib),
    .i_rx_valid_in(prx_dv), .i_rx_error_in(prx_er), .i_carrier_sense_in(pcrs),
    .i_collision_in(pcol), .o_tx_nibble_out(tx_nib), .o_tx_enable_out(tx_en),
    .o_tx_error_out(tx_err), .o_mgmt_clock_out(mdc), .i_mdio_in(mdio_line),
    .o_mdio_out(mdio_out), .o_mdio_oe(mdio_oe), .i_tx_valid(tx_valid), .i_tx_beat(tx_beat),
    .o_tx_ready(tx_ready), .o_tx_underrun(tx_underrun), .o_rx_valid(rx_valid),
    .o_rx_beat(rx_beat), .o_rx_end(rx_end), .o_carrier(carrier), .o_collision(collision),
    .i_mgmt_valid(mgmt_valid), .i_mgmt_cmd(mgmt_cmd), .o_mgmt_ready(mgmt_ready),
    .o_mgmt_done(mgmt_done), .o_mgmt_rdata(rdata));

  phy_model phy (
    .i_half(!fdx), .i_busy(busy), .i_col(col), .i_tx_nibble(tx_nib), .i_tx_enable(tx_en),
    .i_mdc(mdc), .i_mdio(mdio_dly), .o_tx_clk(ptx_clk), .o_rx_clk(prx_clk),
    .o_rx_nibble(prx_nib), .o_rx_valid(prx_dv), .o_rx_error(prx_er), .o_carrier(pcrs),
    .o_collision(pcol), .o_mdio_out(phy_out), .o_mdio_oe(phy_oe));

  always @(negedge mclk) begin
    if (rx_valid === 1'b1) rxq.push_back(rx_beat);
    if (rx_end === 1'b1) rx_ends++;
    if (tx_underrun === 1'b1) underruns++;
    if (tx_err !== 1'b0 || (tx_en !== 1'b1 && tx_nib !== 4'h0)) bad++;
    if (mdio_oe === 1'b1 && phy_oe === 1'b1) bad++;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("Counts: checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic ok, input string m);
    checked++;
    if (ok !== 1'b1) begin
      failures++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask

  task automatic tmo(input string m);
    chk(1'b0, m);
    close_out();
  endtask

  task automatic idle(input int c);
    repeat (c) @(negedge mclk);
  endtask

  task automatic push(input logic l, input logic [3:0] v);
    tx_beat = '{last: l, nibble: v};
    tx_valid = 1'b1;
    for (n = 0; n < 400 && tx_ready !== 1'b1; n++) @(negedge mclk);
    if (n == 400) tmo("tx ready stuck");
    @(negedge mclk);
  endtask

  task automatic wait_txq(input int c);
    for (n = 0; n < 4000 && phy.txq.size() < c; n++) @(negedge mclk);
    if (n == 4000) tmo("tx frame missing");
  endtask

  task automatic mgmt(input logic r, input logic [4:0] ra, input logic [15:0] d,
      input logic [7:0] dv);
    int h;
    logic [63:0] ef;
    h = (dv == 8'h00) ? mii_port_pkg::MGMT_HALF_CYC : int'(dv);
    ef = {32'hffff_ffff, 2'h1, r ? 2'h2 : 2'h1, 5'h03, ra, 2'h2, d};
    @(negedge mclk);
    div = dv;
    mgmt_cmd = '{rd: r, phy_addr: 5'h03, reg_addr: ra, wdata: r ? 16'h0000 : d};
    mgmt_valid = 1'b1;
    @(posedge mclk);
    for (n = 1; n < 3000; n++) begin
      @(negedge mclk);
      mgmt_valid = 1'b0;
      @(posedge mclk);
      #1;
      if (mgmt_done === 1'b1) break;
    end
    if (n == 3000) tmo("mgmt done missing");
    chk(n == 128 * h, "mgmt latency");
    chk(phy.frame === ef, "mgmt frame bits");
    chk(phy.mdc_per == real'(20 * h), "mgmt clock period");
    if (r) chk(rdata === d, "mgmt read data");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    idle(3);
    chk(tx_ready === 1'b1 && mgmt_ready === 1'b1 && tx_en === 1'b0 && mdc === 1'b0
        && mdio_oe === 1'b0, "reset values");
    idle(3);
    rst_n = 1'b1;
    $display("TEST reset done");
    foreach (ROWS[i]) begin
      phy.rx_cycle(ROWS[i]);
      if (ROWS[i][5]) expq.push_back(ROWS[i][4:0]);
    end
    phy.rx_cycle(6'h00);
    idle(8);
    chk(rxq.size() == expq.size() && rx_ends == 2, "rx beat count");
    foreach (expq[i]) chk(rxq[i] === expq[i], "rx beat value");
    $display("TEST rx table done");
    busy = 1'b1;
    idle(4);
    for (int i = 0; i < 16; i++) push(i == 15, 4'(i));
    tx_valid = 1'b0;
    chk(tx_ready === 1'b0, "full buffer refuses");
    idle(40);
    chk(phy.txq.size() == 0 && carrier === 1'b1, "deferred on carrier");
    busy = 1'b0;
    wait_txq(16);
    for (int i = 0; i < 16; i++) chk(phy.txq[i] === 4'(i), "tx nibble");
    phy.txq.delete();
    $display("TEST tx buffer done");
    fdx = 1'b1;
    for (int i = 0; i < 8; i++) push(i == 7, 4'(15 - i));
    tx_valid = 1'b0;
    for (n = 0; n < 400 && tx_en !== 1'b1; n++) @(negedge mclk);
    col = 1'b1;
    wait_txq(8);
    idle(60);
    chk(collision === 1'b1 && phy.txq.size() == 8, "frame completes");
    push(1'b1, 4'h6);
    tx_valid = 1'b0;
    idle(60);
    chk(phy.txq.size() == 8, "collision blocks start");
    col = 1'b0;
    wait_txq(9);
    for (int i = 0; i < 8; i++) chk(phy.txq[i] === 4'(15 - i), "tx nibble");
    chk(phy.txq[8] === 4'h6, "tx after collision");
    phy.txq.delete();
    push(1'b0, 4'h1);
    push(1'b0, 4'h2);
    tx_valid = 1'b0;
    wait_txq(2);
    idle(20);
    chk(underruns == 1 && phy.txq.size() == 2, "underrun pulse");
    $display("TEST tx collision done");
    mgmt(1'b0, 5'h05, 16'ha5c3, 8'h04);
    mgmt(1'b1, 5'h05, 16'ha5c3, 8'h04);
    mgmt(1'b1, 5'h09, 16'h1009, 8'h00);
    $display("TEST mgmt done");
    idle(1);
    mgmt_cmd = '{rd: 1'b1, phy_addr: 5'h03, reg_addr: 5'h01, wdata: 16'h0000};
    mgmt_valid = 1'b1;
    idle(1);
    mgmt_valid = 1'b0;
    idle(100);
    rst_n = 1'b0;
    idle(2);
    chk(mgmt_ready === 1'b1 && mdio_oe === 1'b0 && mdc === 1'b0 && tx_en === 1'b0,
        "second reset");
    rst_n = 1'b1;
    chk(bad == 0, "tx error and idle lines");
    $display("TEST second reset done");
    close_out();
  end

  initial begin
    #900000;
    tmo("run too long");
  end
endmodule
`default_nettype wire
